/* File: design/rsu_pkg.sv */
// constants and types for the byte rotate and shift unit
// Overview of operation
// - rotate_right_circular moves every bit one place toward bit 0; old bit 0 goes to carry and to bit 7.
// - rotate_right_thru_carry moves every bit toward bit 0; old bit 0 goes to carry, old carry to bit 7.
// - arith_shift_left moves every bit one place toward bit 7 and old bit 7 goes to carry.
// - sign takes result bit 7 and zero is set when the 8-bit result is zero, each cleared otherwise.
// - parity/overflow is set on an even count of one bits; half-carry and subtract are cleared.
// - register field 000..101 selects B, C, D, E, H, L and 111 selects the accumulator.
// - the bit-operation prefix comes first, led by DD or FD for an index register, then d, then opcode.
// - opcode bits 7..3 give the operation (00001, 00011, 00100), bits 2..0 the register or 110 for memory.
// - register form takes 8 states, address_pair memory form 15, indexed memory form 23.
// - indexed address is the index register plus the displacement taken as signed two's complement.
package rsu_pkg;

   // register map, byte addresses on the bus
   localparam logic [7:0] ADR_CODE   = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_BCDE   = 8'h08;
   localparam logic [7:0] ADR_HLAF   = 8'h0c;
   localparam logic [7:0] ADR_IDX1   = 8'h10;
   localparam logic [7:0] ADR_IDX2   = 8'h14;
   localparam logic [7:0] ADR_MADDR  = 8'h18;
   localparam logic [7:0] ADR_MDATA  = 8'h1c;

   // status fields
   localparam int ST_BUSY     = 0;
   localparam int ST_ERR      = 1;
   localparam int ST_TCNT_LSB = 8;

   // instruction bytes
   localparam logic [7:0] PFX_BIT  = 8'hcb;
   localparam logic [7:0] PFX_IDX1 = 8'hdd;
   localparam logic [7:0] PFX_IDX2 = 8'hfd;
   localparam logic [4:0] OPF_ROT_CIRC  = 5'h01;
   localparam logic [4:0] OPF_ROT_CARRY = 5'h03;
   localparam logic [4:0] OPF_SHL       = 5'h04;
   localparam logic [2:0] RF_B   = 3'h0;
   localparam logic [2:0] RF_C   = 3'h1;
   localparam logic [2:0] RF_D   = 3'h2;
   localparam logic [2:0] RF_E   = 3'h3;
   localparam logic [2:0] RF_H   = 3'h4;
   localparam logic [2:0] RF_L   = 3'h5;
   localparam logic [2:0] RF_MEM = 3'h6;
   localparam logic [2:0] RF_A   = 3'h7;

   // flag bit positions
   localparam int FB_S  = 7;
   localparam int FB_Z  = 6;
   localparam int FB_H  = 4;
   localparam int FB_PV = 2;
   localparam int FB_N  = 1;
   localparam int FB_C  = 0;

   // execution length in clock states, one state per clock
   localparam int TCNT_W = 5;
   localparam logic [TCNT_W-1:0] T_REG  = 5'h08;
   localparam logic [TCNT_W-1:0] T_PAIR = 5'h0f;
   localparam logic [TCNT_W-1:0] T_IDX  = 5'h17;

   // reset values
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;

   typedef enum logic [2:0] {
      DEC_IDLE,
      DEC_IDX_CB,
      DEC_DISP,
      DEC_OP,
      DEC_IDX_OP
   } rsu_dec_t;

   typedef enum logic [1:0] {
      OPK_ROTATE_RIGHT_CIRCULAR,
      OPK_ROTATE_RIGHT_THRU_CARRY,
      OPK_ARITH_SHIFT_LEFT
   } rsu_op_t;

endpackage

/* File: design/rsu_top.sv */
// byte rotate and shift unit with register file, byte memory and wishbone slave
`timescale 1ns/1ps
module rsu_top #(
   parameter int MEM_AW = 8
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // execution state
   output logic             busy_o
);
   import rsu_pkg::*;

   logic                req;
   logic                wr;
   logic                code_wr;
   logic [7:0]          cbyte;
   logic [4:0]          op_field;
   logic [2:0]          rf;
   logic                op_ok;
   logic                byte_ok;
   logic                start;
   logic                bad;
   logic                is_mem;
   logic [15:0]         idx_val;
   logic [15:0]         ea;
   logic [7:0]          src;
   logic                cin;
   rsu_op_t             kind;
   logic [7:0]          next_res;
   logic                next_co;
   logic [7:0]          next_flags;
   logic [TCNT_W-1:0]   tlen;
   logic [31:0]         next_rdata;

   rsu_dec_t            dstate;
   logic                use_idx;
   logic                use_idx2;
   logic [7:0]          disp;
   logic [TCNT_W-1:0]   tcnt;
   logic [7:0]          res_q;
   logic [7:0]          flags_q;
   logic                dest_mem;
   logic [2:0]          dest_r;
   logic [MEM_AW-1:0]   dest_addr;
   logic                err;
   logic [15:0]         idx1;
   logic [15:0]         idx2;
   logic [15:0]         maddr;
   // slot 6 has no register code, so it holds the flags
   logic [7:0]          gpr [0:7];
   logic [7:0]          mem [0:(2**MEM_AW)-1];

   // one wait state: ack rises the cycle after the request appears
   assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr      = req & wb_we_i;
   assign code_wr = wr & (wb_adr_i == ADR_CODE) & wb_sel_i[0];
   assign cbyte   = wb_dat_i[7:0];
   assign busy_o  = (tcnt != '0);

   // decode of the byte being fed in
   assign op_field = cbyte[7:3];
   assign rf       = cbyte[2:0];
   assign op_ok    = (op_field == OPF_ROT_CIRC) || (op_field == OPF_ROT_CARRY) ||
                     (op_field == OPF_SHL);

   always_comb begin
      byte_ok = 1'b0;
      case (dstate)
         DEC_IDLE:   byte_ok = (cbyte == PFX_BIT) || (cbyte == PFX_IDX1) ||
                               (cbyte == PFX_IDX2);
         DEC_IDX_CB: byte_ok = (cbyte == PFX_BIT);
         DEC_DISP:   byte_ok = 1'b1;
         DEC_OP:     byte_ok = op_ok;
         DEC_IDX_OP: byte_ok = op_ok && (rf == RF_MEM);
         default:    byte_ok = 1'b0;
      endcase
   end

   // a byte fed in while busy is dropped and flagged
   assign bad   = code_wr & (busy_o | ~byte_ok);
   assign start = code_wr & ~busy_o & byte_ok &
                  ((dstate == DEC_OP) || (dstate == DEC_IDX_OP));

   // operand location
   assign is_mem  = (dstate == DEC_IDX_OP) || (rf == RF_MEM);
   assign idx_val = use_idx2 ? idx2 : idx1;
   assign ea      = use_idx ? idx_val + {{8{disp[7]}}, disp}
                            : {gpr[RF_H], gpr[RF_L]};
   assign src     = is_mem ? mem[ea[MEM_AW-1:0]] : gpr[rf];
   assign cin     = gpr[RF_MEM][FB_C];
   assign tlen    = (dstate == DEC_IDX_OP) ? T_IDX :
                    (rf == RF_MEM) ? T_PAIR : T_REG;

   always_comb begin
      case (op_field)
         OPF_ROT_CIRC:  kind = OPK_ROTATE_RIGHT_CIRCULAR;
         OPF_ROT_CARRY: kind = OPK_ROTATE_RIGHT_THRU_CARRY;
         default:       kind = OPK_ARITH_SHIFT_LEFT;
      endcase
   end

   // the shift itself
   always_comb begin
      case (kind)
         OPK_ROTATE_RIGHT_CIRCULAR: begin
            next_res = {src[0], src[7:1]};
            next_co  = src[0];
         end
         OPK_ROTATE_RIGHT_THRU_CARRY: begin
            next_res = {cin, src[7:1]};
            next_co  = src[0];
         end
         OPK_ARITH_SHIFT_LEFT: begin
            next_res = {src[6:0], 1'b0};
            next_co  = src[7];
         end
         default: begin
            next_res = src;
            next_co  = cin;
         end
      endcase
   end

   // bits 5 and 3 of the flags keep their old value
   always_comb begin
      next_flags        = gpr[RF_MEM];
      next_flags[FB_S]  = next_res[7];
      next_flags[FB_Z]  = (next_res == 8'h00);
      next_flags[FB_H]  = 1'b0;
      next_flags[FB_PV] = ~^next_res;
      next_flags[FB_N]  = 1'b0;
      next_flags[FB_C]  = next_co;
   end

   // instruction byte sequencing
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dstate   <= DEC_IDLE;
         use_idx  <= 1'b0;
         use_idx2 <= 1'b0;
         disp     <= RST_BYTE;
      end else if (code_wr && !busy_o) begin
         if (!byte_ok) begin
            dstate <= DEC_IDLE;
         end else begin
            case (dstate)
               DEC_IDLE: begin
                  use_idx  <= (cbyte != PFX_BIT);
                  use_idx2 <= (cbyte == PFX_IDX2);
                  dstate   <= (cbyte == PFX_BIT) ? DEC_OP : DEC_IDX_CB;
               end
               DEC_IDX_CB: dstate <= DEC_DISP;
               DEC_DISP: begin
                  disp   <= cbyte;
                  dstate <= DEC_IDX_OP;
               end
               DEC_OP:     dstate <= DEC_IDLE;
               DEC_IDX_OP: dstate <= DEC_IDLE;
               default:    dstate <= DEC_IDLE;
            endcase
         end
      end
   end

   // execution timer and latched result
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tcnt      <= '0;
         res_q     <= RST_BYTE;
         flags_q   <= RST_BYTE;
         dest_mem  <= 1'b0;
         dest_r    <= RF_B;
         dest_addr <= '0;
      end else if (start) begin
         tcnt      <= tlen;
         res_q     <= next_res;
         flags_q   <= next_flags;
         dest_mem  <= is_mem;
         dest_r    <= rf;
         dest_addr <= ea[MEM_AW-1:0];
      end else if (tcnt != '0) begin
         tcnt <= tcnt - 1'b1;
      end
   end

   // sticky error, set wins over a write-one clear
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err <= 1'b0;
      end else if (bad) begin
         err <= 1'b1;
      end else if (wr && wb_adr_i == ADR_STATUS && wb_sel_i[0] && wb_dat_i[ST_ERR]) begin
         err <= 1'b0;
      end
   end

   // register file; the commit at the last state beats a bus write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < 8; i++) begin
            gpr[i] <= RST_BYTE;
         end
      end else begin
         if (wr && wb_adr_i == ADR_BCDE) begin
            if (wb_sel_i[3]) gpr[RF_B] <= wb_dat_i[31:24];
            if (wb_sel_i[2]) gpr[RF_C] <= wb_dat_i[23:16];
            if (wb_sel_i[1]) gpr[RF_D] <= wb_dat_i[15:8];
            if (wb_sel_i[0]) gpr[RF_E] <= wb_dat_i[7:0];
         end
         if (wr && wb_adr_i == ADR_HLAF) begin
            if (wb_sel_i[3]) gpr[RF_H]   <= wb_dat_i[31:24];
            if (wb_sel_i[2]) gpr[RF_L]   <= wb_dat_i[23:16];
            if (wb_sel_i[1]) gpr[RF_A]   <= wb_dat_i[15:8];
            if (wb_sel_i[0]) gpr[RF_MEM] <= wb_dat_i[7:0];
         end
         if (tcnt == 5'h01) begin
            gpr[RF_MEM] <= flags_q;
            if (!dest_mem) begin
               gpr[dest_r] <= res_q;
            end
         end
      end
   end

   // index registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         idx1 <= RST_WORD;
         idx2 <= RST_WORD;
      end else if (wr) begin
         if (wb_adr_i == ADR_IDX1 && wb_sel_i[0]) idx1[7:0]  <= wb_dat_i[7:0];
         if (wb_adr_i == ADR_IDX1 && wb_sel_i[1]) idx1[15:8] <= wb_dat_i[15:8];
         if (wb_adr_i == ADR_IDX2 && wb_sel_i[0]) idx2[7:0]  <= wb_dat_i[7:0];
         if (wb_adr_i == ADR_IDX2 && wb_sel_i[1]) idx2[15:8] <= wb_dat_i[15:8];
      end
   end

   // memory window pointer, steps after every data access
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         maddr <= RST_WORD;
      end else if (req && wb_adr_i == ADR_MDATA) begin
         maddr <= maddr + 16'h0001;
      end else if (wr && wb_adr_i == ADR_MADDR) begin
         if (wb_sel_i[0]) maddr[7:0]  <= wb_dat_i[7:0];
         if (wb_sel_i[1]) maddr[15:8] <= wb_dat_i[15:8];
      end
   end

   // byte memory; only the low address bits decode, so it aliases upward
   always_ff @(posedge clk_i) begin
      if (tcnt == 5'h01 && dest_mem) begin
         mem[dest_addr] <= res_q;
      end else if (wr && wb_adr_i == ADR_MDATA && wb_sel_i[0]) begin
         mem[maddr[MEM_AW-1:0]] <= wb_dat_i[7:0];
      end
   end

   // read mux, unmapped addresses read zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (wb_adr_i)
         ADR_STATUS: begin
            next_rdata[ST_BUSY] = busy_o;
            next_rdata[ST_ERR]  = err;
            next_rdata[ST_TCNT_LSB +: TCNT_W] = tcnt;
         end
         ADR_BCDE:  next_rdata = {gpr[RF_B], gpr[RF_C], gpr[RF_D], gpr[RF_E]};
         ADR_HLAF:  next_rdata = {gpr[RF_H], gpr[RF_L], gpr[RF_A], gpr[RF_MEM]};
         ADR_IDX1:  next_rdata = {16'h0000, idx1};
         ADR_IDX2:  next_rdata = {16'h0000, idx2};
         ADR_MADDR: next_rdata = {16'h0000, maddr};
         ADR_MDATA: next_rdata = {24'h000000, mem[maddr[MEM_AW-1:0]]};
         default:   next_rdata = 32'h0000_0000;
      endcase
   end

   // bus answer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req;
         if (req && !wb_we_i) begin
            wb_dat_o <= next_rdata;
         end
      end
   end

endmodule

/* File: tb/rsu_top_props.sv */
// assertions on the ports of the rotate and shift unit
`timescale 1ns/1ps
module rsu_top_props
   import rsu_pkg::*;
(
   // clock and reset
   input wire logic        clk_i,
   input wire logic        rst_i,
   // wishbone slave
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   // execution state
   input wire logic        busy_o
);
   logic [7:0] sh1, sh2, sh3, sh4;
   logic [4:0] cnt, len, want;
   logic       code_wr;
   assign code_wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] &&
                    wb_adr_i == ADR_CODE;
   // the form is judged from the last four code bytes, latched once per run
   assign want = (sh3 == PFX_BIT && (sh4 == PFX_IDX1 || sh4 == PFX_IDX2)) ? T_IDX :
                 (sh1[2:0] == RF_MEM) ? T_PAIR : T_REG;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         {sh4, sh3, sh2, sh1} <= 32'h0;
      end else if (code_wr) begin
         {sh4, sh3, sh2, sh1} <= {sh3, sh2, sh1, wb_dat_i[7:0]};
      end
   end
   always_ff @(posedge clk_i) begin
      cnt <= (rst_i || !busy_o) ? 5'h00 : cnt + 5'h01;
      len <= (busy_o && cnt == 5'h00) ? want : len;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_rd_ack;
      wb_ack_o && !wb_we_i;
   endsequence
   property p_ack_resp;   s_req |=> wb_ack_o; endproperty
   property p_ack_pulse;  wb_ack_o |=> !wb_ack_o; endproperty
   property p_ack_cause;  $rose(wb_ack_o) |-> $past(wb_stb_i) && $past(wb_cyc_i); endproperty
   property p_busy_start; $rose(busy_o) |-> $past(code_wr); endproperty
   property p_busy_len;   $fell(busy_o) |-> cnt == len; endproperty
   property p_busy_bound; busy_o |-> cnt < T_IDX; endproperty
   property p_dat_hold;   !wb_ack_o |-> $stable(wb_dat_o); endproperty
   property p_code_rd0;   s_rd_ack and wb_adr_i == ADR_CODE |-> wb_dat_o == 32'h0; endproperty
   property p_stat_busy;
      s_rd_ack and wb_adr_i == ADR_STATUS |-> wb_dat_o[ST_BUSY] == $past(busy_o);
   endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("ack missing after request");
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
   a_busy_start: assert property (p_busy_start) else $error("busy without code byte");
   a_busy_len: assert property (p_busy_len) else $error("busy length wrong for form");
   a_busy_bound: assert property (p_busy_bound) else $error("busy too long");
   a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
   a_code_rd0: assert property (p_code_rd0) else $error("code register read not zero");
   a_stat_busy: assert property (p_stat_busy) else $error("status busy bit wrong");
endmodule
bind rsu_top rsu_top_props u_rsu_top_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

/* File: tb/tb.sv */
// self-checking bench for the rotate and shift unit
`timescale 1ns/1ps
module tb;
   import rsu_pkg::*;
   logic        clk_i = 0;
   logic        rst_i = 1;
   logic        wb_cyc_i = 0;
   logic        wb_stb_i = 0;
   logic        wb_we_i = 0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        busy_o;
   int          bad_count = 0;
   int          n_checks = 0;
   int          seed = 82117;
   int          bcnt = 0;
   logic [31:0] rq[$];
   logic [31:0] lq[$];
   logic [7:0]  r[8];
   logic [4:0]  opf[3] = '{OPF_ROT_CIRC, OPF_ROT_CARRY, OPF_SHL};
   always #12.5 clk_i = ~clk_i;
   rsu_top u_rsu_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));
   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // request held until ack is sampled, then released for at least one cycle
   task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (n >= 20) begin
         bad_count++;
         end_sim();
      end
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, logic [31:0] exp);
      rq.push_back(exp);
      wb(1'b0, a, 32'h0);
   endtask
   task automatic code(logic [7:0] b);
      wb(1'b1, ADR_CODE, {24'h0, b});
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (busy_o !== 1'b0 && n < 40);
      if (n >= 40) begin
         bad_count++;
         end_sim();
      end
   endtask
   function automatic logic [8:0] calc(int op, logic [7:0] v, logic ci);
      case (op)
         0: return {v[0], v[0], v[7:1]};
         1: return {v[0], ci, v[7:1]};
         default: return {v[7], v[6:0], 1'b0};
      endcase
   endfunction
   // read results, the held write direction separates reads from writes
   always @(posedge clk_i)
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0)
         chk("read data", rq.pop_front(), wb_dat_o);
   always @(posedge clk_i)
      if (busy_o === 1'b1) begin
         bcnt++;
      end else if (bcnt > 0) begin
         chk("busy length", lq.pop_front(), bcnt);
         bcnt = 0;
      end
   initial begin
      logic [7:0]  v, d, ad, res;
      logic [8:0]  o;
      logic [15:0] ix;
      logic [2:0]  fld;
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int op = 0; op < 3; op++)
         for (int k = 0; k < 10; k++) begin
            for (int i = 0; i < 8; i++)
               r[i] = 8'($random(seed));
            v = 8'($random(seed));
            d = 8'($random(seed));
            ix = 16'($random(seed));
            fld = (k < 8) ? k[2:0] : RF_MEM;
            // wrap to 256 bytes, so the signed offset only shows mod 256
            ad = (k == 6) ? r[5] : ix[7:0] + d;
            wb(1'b1, ADR_BCDE, {r[0], r[1], r[2], r[3]});
            wb(1'b1, ADR_HLAF, {r[4], r[5], r[7], r[6]});
            if (fld == RF_MEM) begin
               if (k > 7)
                  wb(1'b1, (k == 8) ? ADR_IDX1 : ADR_IDX2, {16'h0, ix});
               wb(1'b1, ADR_MADDR, {24'h0, ad});
               wb(1'b1, ADR_MDATA, {24'h0, v});
            end else
               v = r[fld];
            if (k > 7) begin
               code((k == 8) ? PFX_IDX1 : PFX_IDX2);
               code(PFX_BIT);
               code(d);
            end else
               code(PFX_BIT);
            lq.push_back((k > 7) ? T_IDX : (k == 6) ? T_PAIR : T_REG);
            code({opf[op], fld});
            wait_idle();
            o = calc(op, v, r[6][0]);
            res = o[7:0];
            r[6] = {res[7], res == 8'h00, r[6][5], 1'b0, r[6][3], ~^res, 1'b0, o[8]};
            if (fld != RF_MEM)
               r[fld] = res;
            rd(ADR_BCDE, {r[0], r[1], r[2], r[3]});
            rd(ADR_HLAF, {r[4], r[5], r[7], r[6]});
            if (fld == RF_MEM) begin
               wb(1'b1, ADR_MADDR, {24'h0, ad});
               rd(ADR_MDATA, {24'h0, res});
            end
         end
      // a byte fed while busy is dropped and flags the error
      code(PFX_BIT);
      lq.push_back(T_REG);
      code({OPF_ROT_CIRC, RF_B});
      code(8'h55);
      wait_idle();
      rd(ADR_STATUS, 32'h2);
      wb(1'b1, ADR_STATUS, 32'h2);
      rd(ADR_STATUS, 32'h0);
      rd(ADR_CODE, 32'h0);
      rd(8'h20, 32'h0);
      // an indexed opcode naming a register is refused and never starts
      code(PFX_IDX1);
      code(PFX_BIT);
      code(8'h00);
      code({OPF_SHL, RF_B});
      rd(ADR_STATUS, 32'h2);
      repeat (3) @(posedge clk_i);
      // an instruction that never ran would leave its length note behind
      chk("pending busy", 32'h0, lq.size());
      chk("pending reads", 32'h0, rq.size());
      end_sim();
   end
endmodule
